// ===== design/cell_monitor_regs.svh
`ifndef CELL_MONITOR_REGS_SVH
`define CELL_MONITOR_REGS_SVH
// ==========================================================
// Register byte addresses
`define CFG_A_LO_ADDR 12'h000
`define CFG_A_HI_ADDR 12'h004
`define CFG_B_LO_ADDR 12'h008
`define CFG_B_HI_ADDR 12'h00c
`define CELL_BASE_ADDR 12'h010
`define AUX_BASE_ADDR 12'h058
`define OVERLAP_CTRL_ADDR 12'h070
`define RESULT_COUNT 5'd24
// ==========================================================
// Reset values
`define CFG_A_RESET 48'h0000_0000_0000
`define CFG_B_RESET 48'h0000_0000_0000
// ==========================================================
// Field positions, group A
`define FA_CONV_OPT 0
`define FA_DIS_TMR_EN 1
`define FA_REF_ON 2
`define FA_PD_LO 3
`define FA_UV_LO 8
`define FA_OV_LO 20
`define FA_DIS_LO 32
`define FA_TMO_LO 44
// Field positions, group B
`define FB_PD_LO 0
`define FB_DIS_LO 4
`define FB_DIS17 8
`define FB_PIN9_DIS 10
`define FB_TMR_MON 11
`define FB_PATH_LO 12
`define FB_FORCE_FAIL 14
`define FB_MUTE 15
`define FB_USED_MASK 48'h0000_0000_ffff
`endif

// ===== design/cell_monitor_pkg.sv
package cell_monitor_pkg;
  typedef logic [15:0] result_type;
  typedef logic [47:0] group_type;
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_CFG,
    SEL_RESULT,
    SEL_OVERLAP
  } region_type;
endpackage

// ===== design/result_if.sv
`timescale 1ns/1ps
`default_nettype none
interface result_if;
  logic [15:0] result [24];
  logic overlap_valid;
  logic [15:0] overlap_c7;
  logic [15:0] overlap_c13;
  modport store (output result);
  modport user (input result, input overlap_valid, input overlap_c7, input overlap_c13);
  modport feed (output overlap_valid, output overlap_c7, output overlap_c13);
endinterface
`default_nettype wire

// ===== design/result_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "cell_monitor_regs.svh"
module result_store (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [23:0] meas_we,
  input wire logic [15:0] meas_data,
  result_if.store rif
);
  // ==========================================================
  // Measurement storage, loaded only by conversion side
  genvar i;
  generate
    for (i = 0; i < 24; i++) begin : g_res
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rif.result[i] <= 16'h0000;
        end else if (meas_we[i]) begin
          rif.result[i] <= meas_data;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== design/overlap_hold.sv
`timescale 1ns/1ps
`default_nettype none
module overlap_hold (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic overlap_done,
  input wire logic overlap_clear,
  input wire logic [15:0] adc1_cell7,
  input wire logic [15:0] adc2_cell13,
  result_if.feed rif
);
  // ==========================================================
  // Overlap results; completion wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rif.overlap_valid <= 1'b0;
      rif.overlap_c7 <= 16'h0000;
      rif.overlap_c13 <= 16'h0000;
    end else if (overlap_done) begin
      rif.overlap_valid <= 1'b1;
      rif.overlap_c7 <= adc1_cell7;
      rif.overlap_c13 <= adc2_cell13;
    end else if (overlap_clear) begin
      rif.overlap_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== design/cell_monitor_register_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "cell_monitor_regs.svh"
// Overview of operation
// (RULE1) Group A byte 0: conv option, timer enable, reference on, GP_PIN_PULLDOWN_CTRL-5 pulldowns.
// (RULE2) Undervoltage in bytes 1 and 2 low; overvoltage in byte 2 high and 3.
// (RULE3) Group A byte 4-5: discharge cells 1-12, then four-bit timeout.
// (RULE4) Group B byte 0: GPIO6-9 pulldowns, then discharge cells 13-16.
// (RULE5) Group B byte 1: cells 17-18, pin9 discharge, monitor, path, fail, mute.
// (RULE6) Group B bytes 2 to 5 reserved, read as zero.
// (RULE7) Cell groups read-only, three 16-bit results each, low byte first.
// (RULE8) Cell groups A-F carry cells 1-3 through 16-18 in order.
// (RULE9) After overlap command, group C bytes 2-3 show ADC1 cell 7.
// (RULE10) After overlap command, group E bytes 2-3 show ADC2 cell 13.
// (RULE11) Aux group A holds GPIO 1-3 results, low byte first.
// (RULE12) Aux group B holds GPIO 4, 5 and second reference results.
// (RULE13) Writes to result groups leave stored measurements unchanged.
module cell_monitor_register_map (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [23:0] meas_we,
  input wire logic [15:0] meas_data,
  input wire logic overlap_done,
  input wire logic [15:0] adc1_cell7,
  input wire logic [15:0] adc2_cell13,
  output logic conv_option_select,
  output logic discharge_timer_enable,
  output logic reference_power_on,
  output logic [8:0] gp_pin_pulldown_ctrl,
  output logic [11:0] undervolt_threshold,
  output logic [11:0] overvolt_threshold,
  output logic [17:0] cell_discharge_enable,
  output logic [3:0] discharge_timeout,
  output logic pin9_discharge_enable,
  output logic discharge_timer_monitor_en,
  output logic [1:0] path_select,
  output logic forced_redundancy_fail,
  output logic mute
);
  // ==========================================================
  // Storage
  cell_monitor_pkg::group_type cfg_a_q;
  cell_monitor_pkg::group_type cfg_b_q;
  logic overlap_clear;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_word;
  logic rd_err;
  logic wr_err;
  result_if rif ();

  result_store u_store (
    .pclk(pclk),
    .presetn(presetn),
    .meas_we(meas_we),
    .meas_data(meas_data),
    .rif(rif.store)
  );

  overlap_hold u_overlap (
    .pclk(pclk),
    .presetn(presetn),
    .overlap_done(overlap_done),
    .overlap_clear(overlap_clear),
    .adc1_cell7(adc1_cell7),
    .adc2_cell13(adc2_cell13),
    .rif(rif.feed)
  );

  // ==========================================================
  // Helpers
  function automatic logic [47:0] merge_word(input logic [47:0] old, input logic hi,
                                             input logic [31:0] data, input logic [3:0] strb);
    logic [47:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b] && (!hi || b < 2)) begin
        res[(hi ? 32 : 0) + b * 8 +: 8] = data[b * 8 +: 8];
      end
    end
    return res;
  endfunction

  // Result for slot index; overlap substitution applied
  function automatic logic [15:0] pick_result(input logic [4:0] idx);
    logic [15:0] v;
    v = rif.result[idx];
    if (rif.overlap_valid && idx == 5'd7) begin
      v = rif.overlap_c7; // see (RULE9)
    end
    if (rif.overlap_valid && idx == 5'd13) begin
      v = rif.overlap_c13; // see (RULE10)
    end
    return v;
  endfunction

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign pslverr = psel && penable && (pwrite ? wr_err : rd_err);

  // ==========================================================
  // Write path
  always_comb begin
    wr_err = 1'b0;
    overlap_clear = 1'b0;
    unique case (paddr)
      `CFG_A_LO_ADDR, `CFG_A_HI_ADDR, `CFG_B_LO_ADDR, `CFG_B_HI_ADDR: wr_err = 1'b0;
      `OVERLAP_CTRL_ADDR: overlap_clear = wr_en && pstrb[0] && pwdata[0];
      default: wr_err = 1'b1; // see (RULE13)
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_a_q <= `CFG_A_RESET;
    end else if (wr_en && (paddr == `CFG_A_LO_ADDR || paddr == `CFG_A_HI_ADDR)) begin
      cfg_a_q <= merge_word(cfg_a_q, paddr == `CFG_A_HI_ADDR, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_b_q <= `CFG_B_RESET;
    end else if (wr_en && (paddr == `CFG_B_LO_ADDR || paddr == `CFG_B_HI_ADDR)) begin
      cfg_b_q <= merge_word(cfg_b_q, paddr == `CFG_B_HI_ADDR, pwdata, pstrb)
                 & `FB_USED_MASK; // see (RULE6)
    end
  end

  // ==========================================================
  // Read path
  always_comb begin
    logic [4:0] idx;
    idx = 5'd0;
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr == `CFG_A_LO_ADDR) begin
      rd_word = cfg_a_q[31:0];
    end else if (paddr == `CFG_A_HI_ADDR) begin
      rd_word = {16'h0000, cfg_a_q[47:32]};
    end else if (paddr == `CFG_B_LO_ADDR) begin
      rd_word = cfg_b_q[31:0];
    end else if (paddr == `CFG_B_HI_ADDR) begin
      rd_word = {16'h0000, cfg_b_q[47:32]};
    end else if (paddr == `OVERLAP_CTRL_ADDR) begin
      rd_word = {31'h0000_0000, rif.overlap_valid};
    end else if (paddr >= `CELL_BASE_ADDR && paddr < `OVERLAP_CTRL_ADDR &&
                 paddr[1:0] == 2'b00) begin
      // Cells 1-18 then aux slots from AUX_BASE_ADDR, one result per word
      idx = 5'((paddr - `CELL_BASE_ADDR) >> 2); // see (RULE7) (RULE8) (RULE11) (RULE12)
      rd_word = {16'h0000, pick_result(idx)};
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      prdata <= rd_word;
    end
  end

  // ==========================================================
  // Field outputs
  always_comb begin
    conv_option_select = cfg_a_q[`FA_CONV_OPT]; // see (RULE1)
    discharge_timer_enable = cfg_a_q[`FA_DIS_TMR_EN];
    reference_power_on = cfg_a_q[`FA_REF_ON];
    gp_pin_pulldown_ctrl = {cfg_b_q[`FB_PD_LO +: 4], cfg_a_q[`FA_PD_LO +: 5]}; // see (RULE4)
    undervolt_threshold = cfg_a_q[`FA_UV_LO +: 12]; // see (RULE2)
    overvolt_threshold = cfg_a_q[`FA_OV_LO +: 12];
    cell_discharge_enable = {cfg_b_q[`FB_DIS17 +: 2], cfg_b_q[`FB_DIS_LO +: 4],
                             cfg_a_q[`FA_DIS_LO +: 12]}; // see (RULE3) (RULE5)
    discharge_timeout = cfg_a_q[`FA_TMO_LO +: 4];
    pin9_discharge_enable = cfg_b_q[`FB_PIN9_DIS];
    discharge_timer_monitor_en = cfg_b_q[`FB_TMR_MON];
    path_select = cfg_b_q[`FB_PATH_LO +: 2];
    forced_redundancy_fail = cfg_b_q[`FB_FORCE_FAIL];
    mute = cfg_b_q[`FB_MUTE];
  end
endmodule
`default_nettype wire

// ===== test/cell_monitor_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cell_monitor_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic overlap_done,
  input wire logic conv_option_select,
  input wire logic discharge_timer_enable,
  input wire logic reference_power_on,
  input wire logic [8:0] gp_pin_pulldown_ctrl,
  input wire logic [11:0] undervolt_threshold,
  input wire logic [11:0] overvolt_threshold,
  input wire logic [17:0] cell_discharge_enable,
  input wire logic [3:0] discharge_timeout,
  input wire logic pin9_discharge_enable,
  input wire logic discharge_timer_monitor_en,
  input wire logic [1:0] path_select,
  input wire logic forced_redundancy_fail,
  input wire logic mute
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic rd;
  assign wr = psel && penable && pwrite && pready;
  assign rd = psel && penable && !pwrite;
  a_cfga_byte0: assert property (wr && paddr == 12'h000 && pstrb[0] |=>
    {gp_pin_pulldown_ctrl[4:0], reference_power_on, discharge_timer_enable,
    conv_option_select} == $past(pwdata[7:0])) else $error("group A byte 0 field");
  a_uv_field: assert property (wr && paddr == 12'h000 && pstrb[2:1] == 2'h3 |=>
    undervolt_threshold == $past(pwdata[19:8])) else $error("undervoltage field");
  a_ov_field: assert property (wr && paddr == 12'h000 && pstrb[3:2] == 2'h3 |=>
    overvolt_threshold == $past(pwdata[31:20])) else $error("overvoltage field");
  a_dis_tmo: assert property (wr && paddr == 12'h004 && pstrb[1:0] == 2'h3 |=>
    {discharge_timeout, cell_discharge_enable[11:0]} == $past(pwdata[15:0]))
    else $error("discharge low field");
  a_cfgb_byte0: assert property (wr && paddr == 12'h008 && pstrb[0] |=>
    {cell_discharge_enable[15:12], gp_pin_pulldown_ctrl[8:5]} == $past(pwdata[7:0]))
    else $error("group B byte 0 field");
  a_cfgb_byte1: assert property (wr && paddr == 12'h008 && pstrb[1] |=>
    {mute, forced_redundancy_fail, path_select, discharge_timer_monitor_en,
    pin9_discharge_enable, cell_discharge_enable[17:16]} == $past(pwdata[15:8]))
    else $error("group B byte 1 field");
  a_rsvd_zero: assert property (rd && paddr == 12'h008 |-> prdata[31:16] == 16'h0000)
    else $error("reserved bytes not zero");
  a_rsvd_hi: assert property (rd && paddr == 12'h00c |-> prdata == 32'h0)
    else $error("reserved word not zero");
  a_result_ro: assert property (wr && paddr >= 12'h010 && paddr <= 12'h06c |-> pslverr)
    else $error("result write accepted");
  c_cfg_write: cover property (wr && paddr == 12'h000);
  c_ro_write: cover property (wr && pslverr);
  c_overlap: cover property (overlap_done);
endmodule
bind cell_monitor_register_map cell_monitor_checker u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .overlap_done,
  .conv_option_select, .discharge_timer_enable, .reference_power_on, .gp_pin_pulldown_ctrl,
  .undervolt_threshold, .overvolt_threshold, .cell_discharge_enable, .discharge_timeout,
  .pin9_discharge_enable, .discharge_timer_monitor_en, .path_select, .forced_redundancy_fail,
  .mute);
`default_nettype wire

// ===== test/apb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  end
  // One full transfer, then an idle cycle
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ===== test/cell_monitor_register_map_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cell_monitor_register_map_tb_top;
  logic pclk = 0, presetn = 0, overlap_done = 0;
  logic [23:0] meas_we = 0;
  logic [15:0] meas_data = 0, adc1 = 0, adc2 = 0;
  logic psel, penable, pwrite, pready, pslverr, cos, dte, rpo, p9, mon, ffail, mute;
  logic [11:0] paddr, uv, ov;
  logic [31:0] pwdata, prdata, rdat, v;
  logic [3:0] pstrb, tmo;
  logic [8:0] pd;
  logic [17:0] dis;
  logic [1:0] ps;
  logic err;
  logic [31:0] cfg_m [4];
  int cell_m [24];
  int num_errors = 0, n_checks = 0, seed = 74033;
  always #20 pclk = ~pclk;
  apb_host_model u_host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb));
  cell_monitor_register_map u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_we(meas_we),
    .meas_data(meas_data), .overlap_done(overlap_done), .adc1_cell7(adc1),
    .adc2_cell13(adc2), .conv_option_select(cos), .discharge_timer_enable(dte),
    .reference_power_on(rpo), .gp_pin_pulldown_ctrl(pd), .undervolt_threshold(uv),
    .overvolt_threshold(ov), .cell_discharge_enable(dis), .discharge_timeout(tmo),
    .pin9_discharge_enable(p9), .discharge_timer_monitor_en(mon), .path_select(ps),
    .forced_redundancy_fail(ffail), .mute(mute));
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_chk(string name, logic [11:0] a, logic [31:0] exp);
    u_host.xfer(1'b0, a, 32'h0, rdat, err);
    check(name, rdat, exp);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    $display("watchdog expired");
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) rd_chk("cfg reset", 12'(4 * i), 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      u_host.xfer(1'b1, 12'(4 * i), v, rdat, err);
      cfg_m[i] = (i == 0) ? v : (i == 3) ? 32'h0 : v & 32'h0000ffff;
    end
    for (int i = 0; i < 4; i++) rd_chk("cfg word", 12'(4 * i), cfg_m[i]);
    check("a0", {pd[4:0], rpo, dte, cos}, cfg_m[0][7:0]);
    check("uv", uv, cfg_m[0][19:8]);
    check("ov", ov, cfg_m[0][31:20]);
    check("a45", {tmo, dis[11:0]}, cfg_m[1][15:0]);
    check("b0", {dis[15:12], pd[8:5]}, cfg_m[2][7:0]);
    check("b1", {mute, ffail, ps, mon, p9, dis[17:16]}, cfg_m[2][15:8]);
    $display("config test done");
    for (int i = 0; i < 24; i++) begin
      @(posedge pclk);
      v = $random(seed);
      meas_we <= 24'h1 << i;
      meas_data <= v[15:0];
      cell_m[i] = v[15:0];
    end
    @(posedge pclk);
    meas_we <= '0;
    for (int i = 0; i < 24; i++) begin
      rd_chk("result", 12'h010 + 12'(4 * i), cell_m[i]);
      u_host.xfer(1'b1, 12'h010 + 12'(4 * i), 32'hffffffff, rdat, err);
      check("ro err", err, 1'b1);
      rd_chk("cell kept", 12'h010 + 12'(4 * i), cell_m[i]);
    end
    $display("result test done");
    v = $random(seed);
    @(posedge pclk);
    adc1 <= v[15:0];
    adc2 <= v[31:16];
    overlap_done <= 1'b1;
    @(posedge pclk);
    overlap_done <= 1'b0;
    rd_chk("ovl c", 12'h02c, v[15:0]);
    rd_chk("ovl e", 12'h044, v[31:16]);
    rd_chk("ovl flag", 12'h070, 32'h1);
    rd_chk("ovl slot 17", 12'h050, cell_m[16]);
    u_host.xfer(1'b1, 12'h070, 32'h1, rdat, err);
    rd_chk("ovl clr", 12'h02c, cell_m[7]);
    rd_chk("ovl clr e", 12'h044, cell_m[13]);
    rd_chk("unmapped", 12'h074, 32'h0);
    check("unmapped err", err, 1'b1);
    $display("overlap test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
